// *** cis_pkg.sv ***
// Constants and types shared by the 8-bit CPU core and its helper units.
package cis_pkg;
	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} cis_ccr_t;

	typedef struct packed {
		logic [7:0] res;
		cis_ccr_t   ccr;
	} cis_alu_out_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} cis_mem_req_t;

	typedef enum logic [3:0] {
		ST_FETCH  = 4'h0, ST_WAIT   = 4'h1, ST_DECODE = 4'h3, ST_ADDR   = 4'h2,
		ST_OPND1  = 4'h6, ST_ACCESS = 4'h7, ST_EXEC   = 4'h5, ST_BROFF  = 4'h4,
		ST_OPND2  = 4'hC, ST_PUSH   = 4'hD, ST_PULL   = 4'hF, ST_PULLD  = 4'hE,
		ST_VEC_HI = 4'hA, ST_VEC_LO = 4'hB, ST_SLEEP  = 4'h9
	} cis_state_t;

	localparam logic [15:0] RESET_VEC     = 16'hFFFE;
	localparam logic [15:0] SOFT_TRAP_VEC = 16'hFFFC;
	localparam logic [15:0] IRQ_VEC       = 16'hFFFA;
	localparam logic [15:0] PC_RESET      = 16'h0000;
	localparam logic [7:0]  SP_RESET      = 8'hFF;
	localparam logic [1:0]  STACK_TOP     = 2'h3;
	localparam logic [7:0]  DATA_RESET    = 8'h00;
	localparam logic [7:0]  PAGE_ZERO     = 8'h00;
	localparam cis_ccr_t    CCR_RESET     = 5'h08;
	localparam logic [2:0]  CCR_PAD       = 3'h7;
	localparam logic [2:0]  STK_PCL = 3'h0, STK_PCH = 3'h1, STK_IDX = 3'h2;
	localparam logic [2:0]  STK_ACC = 3'h3, STK_CCR = 3'h4;

	// Opcode groups, selected by the high nibble.
	localparam logic [3:0] GRP_BIT_BRANCH = 4'h0, GRP_BIT_WRITE = 4'h1, GRP_REL_BRANCH = 4'h2;
	localparam logic [3:0] GRP_RMW_DIR = 4'h3, GRP_RMW_ACC = 4'h4, GRP_RMW_IDX = 4'h5;
	localparam logic [3:0] GRP_RMW_IX1 = 4'h6, GRP_RMW_IX0 = 4'h7;
	localparam logic [3:0] GRP_CTRL_A = 4'h8, GRP_CTRL_B = 4'h9, GRP_IMM = 4'hA;
	localparam logic [3:0] GRP_DIR = 4'hB, GRP_EXT = 4'hC, GRP_IX2 = 4'hD;
	localparam logic [3:0] GRP_IX1 = 4'hE, GRP_IX0 = 4'hF;

	localparam logic [3:0] SIGN_FLIP_OP = 4'h0, ONES_COMP_OP = 4'h3, LOGIC_SHIFT_RIGHT_OP = 4'h4;
	localparam logic [3:0] ROTATE_RIGHT_CARRY_OP = 4'h6, ARITH_SHIFT_RIGHT_OP = 4'h7;
	localparam logic [3:0] LOGIC_SHIFT_LEFT_OP = 4'h8, ARITH_SHIFT_LEFT_OP = 4'h8;
	localparam logic [3:0] ROTATE_LEFT_CARRY_OP = 4'h9, MINUS_ONE_OP = 4'hA, PLUS_ONE_OP = 4'hC;
	localparam logic [3:0] PROBE_FLAGS_OP = 4'hD, ZERO_FILL_OP = 4'hF;

	localparam logic [3:0] RM_SUBTRACT = 4'h0, RM_COMPARE_ACC = 4'h1, RM_SUBTRACT_CARRY = 4'h2;
	localparam logic [3:0] RM_COMPARE_IDX = 4'h3, RM_AND = 4'h4, RM_AND_TEST = 4'h5;
	localparam logic [3:0] RM_LOAD_ACC = 4'h6, RM_STORE_ACC = 4'h7, RM_XOR = 4'h8;
	localparam logic [3:0] RM_ADD_CARRY = 4'h9, RM_OR = 4'hA, RM_ADD = 4'hB;
	localparam logic [3:0] UNCONDITIONAL_GOTO_OP = 4'hC, SUBROUTINE_CALL_OP = 4'hD;
	localparam logic [3:0] RM_LOAD_IDX = 4'hE, RM_STORE_IDX = 4'hF;

	localparam logic [3:0] BR_ALWAYS = 4'h0, BR_NEVER = 4'h1, BR_CARRY_CLEAR = 4'h4;
	localparam logic [3:0] BR_CARRY_SET = 4'h5, BR_NOT_EQUAL = 4'h6, BR_EQUAL = 4'h7;
	localparam logic [3:0] BR_PLUS = 4'hA, BR_MINUS = 4'hB;

	localparam logic [7:0] INTERRUPT_RETURN_OP = 8'h80, SUB_RETURN_OP = 8'h81;
	localparam logic [7:0] SOFT_TRAP_OP = 8'h83, OSC_HALT_OP = 8'h8E, CLOCK_IDLE_OP = 8'h8F;
	localparam logic [7:0] ACC_TO_INDEX_OP = 8'h97, CARRY_ZERO_OP = 8'h98, CARRY_ONE_OP = 8'h99;
	localparam logic [7:0] IRQ_MASK_OFF_OP = 8'h9A, IRQ_MASK_ON_OP = 8'h9B;
	localparam logic [7:0] STACK_POINTER_INIT_OP = 8'h9C, IDLE_OP = 8'h9D;
	localparam logic [7:0] INDEX_TO_ACC_OP = 8'h9F, UNSIGNED_PRODUCT_OP = 8'h42;
endpackage

// *** cis_alu.sv ***
// Arithmetic and logic unit for register/memory and read-modify-write operations.
`timescale 1ns/1ps
module cis_alu (
	input  wire logic              rmw,
	input  wire logic [3:0]        op,
	input  wire logic [7:0]        lhs,
	input  wire logic [7:0]        rhs,
	input  cis_pkg::cis_ccr_t      ccr_in,
	output cis_pkg::cis_alu_out_t  out
);
	import cis_pkg::*;

	logic [8:0] wide;

	always_comb
	begin
		wide = 9'h000;
		out.res = rhs;
		out.ccr = ccr_in;
		if (rmw)
		begin
			unique case (op)
				SIGN_FLIP_OP:          begin out.res = 8'h00 - rhs; out.ccr.c = |rhs; end
				ONES_COMP_OP:          begin out.res = ~rhs; out.ccr.c = 1'b1; end
				LOGIC_SHIFT_RIGHT_OP:  begin out.res = {1'b0, rhs[7:1]}; out.ccr.c = rhs[0]; end
				ROTATE_RIGHT_CARRY_OP: begin out.res = {ccr_in.c, rhs[7:1]}; out.ccr.c = rhs[0]; end
				ARITH_SHIFT_RIGHT_OP:  begin out.res = {rhs[7], rhs[7:1]}; out.ccr.c = rhs[0]; end
				LOGIC_SHIFT_LEFT_OP:   begin out.res = {rhs[6:0], 1'b0}; out.ccr.c = rhs[7]; end
				ROTATE_LEFT_CARRY_OP:  begin out.res = {rhs[6:0], ccr_in.c}; out.ccr.c = rhs[7]; end
				MINUS_ONE_OP:          out.res = rhs - 8'h01;
				PLUS_ONE_OP:           out.res = rhs + 8'h01;
				ZERO_FILL_OP:          begin out.res = 8'h00; out.ccr.c = 1'b0; end
				default:               out.res = rhs;
			endcase
		end
		else
		begin
			unique case (op)
				RM_SUBTRACT, RM_COMPARE_ACC, RM_COMPARE_IDX, RM_SUBTRACT_CARRY:
				begin
					wide = {1'b0, lhs} - {1'b0, rhs}
						- {8'h00, (op == RM_SUBTRACT_CARRY) & ccr_in.c};
					out.res = wide[7:0];
					out.ccr.c = wide[8];
				end
				RM_AND, RM_AND_TEST:         out.res = lhs & rhs;
				RM_STORE_ACC, RM_STORE_IDX:  out.res = lhs;
				RM_XOR:                      out.res = lhs ^ rhs;
				RM_OR:                       out.res = lhs | rhs;
				RM_ADD_CARRY, RM_ADD:
				begin
					wide = {1'b0, lhs} + {1'b0, rhs} + {8'h00, (op == RM_ADD_CARRY) & ccr_in.c};
					out.res = wide[7:0];
					out.ccr.c = wide[8];
					out.ccr.h = lhs[4] ^ rhs[4] ^ wide[4];
				end
				default:                     out.res = rhs;
			endcase
		end
		out.ccr.n = out.res[7];
		out.ccr.z = (out.res == 8'h00);
	end
endmodule

// *** cis_bitop.sv ***
// Single-bit modify, bit test and relative branch condition unit.
`timescale 1ns/1ps
module cis_bitop (
	input  wire logic [7:0]    byte_in,
	input  wire logic [2:0]    bit_sel,
	input  wire logic          bit_level,
	input  wire logic [3:0]    cond,
	input  cis_pkg::cis_ccr_t  ccr,
	output logic [7:0]         byte_out,
	output logic               bit_val,
	output logic               rel_take
);
	import cis_pkg::*;

	always_comb
	begin
		byte_out = byte_in;
		byte_out[bit_sel] = bit_level;
		bit_val = byte_in[bit_sel];
		unique case (cond)
			BR_ALWAYS:      rel_take = 1'b1;
			BR_CARRY_CLEAR: rel_take = ~ccr.c;
			BR_CARRY_SET:   rel_take = ccr.c;
			BR_NOT_EQUAL:   rel_take = ~ccr.z;
			BR_EQUAL:       rel_take = ccr.z;
			BR_PLUS:        rel_take = ~ccr.n;
			BR_MINUS:       rel_take = ccr.n;
			default:        rel_take = 1'b0;
		endcase
	end
endmodule

// *** cis_core.sv ***
// Sequencer of the 8-bit CPU core: fetch, addressing, execution, stack and sleep.
`timescale 1ns/1ps
module cis_core (
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              irq_n,
	input  wire logic [7:0]        mem_rdata,
	output cis_pkg::cis_mem_req_t  mem_req,
	output logic                   osc_stopped,
	output logic                   cpu_idle
);
	import cis_pkg::*;

	cis_state_t    state;
	cis_state_t    ret_state;
	cis_ccr_t      ccr;
	cis_alu_out_t  alu_out;
	logic [7:0]    acc;
	logic [7:0]    idx;
	logic [7:0]    sp;
	logic [7:0]    opcode;
	logic [15:0]   pc;
	logic [15:0]   ea;
	logic [15:0]   vec;
	logic [15:0]   product;
	logic [2:0]    stk_cnt;
	logic [2:0]    stk_last;
	logic          push_vec;
	logic          br_take;
	logic [3:0]    grp;
	logic [3:0]    low;
	logic          rmw_grp;
	logic [7:0]    alu_lhs;
	logic [7:0]    alu_rhs;
	logic [7:0]    push_data;
	logic [7:0]    bit_byte;
	logic          bit_val;
	logic          rel_take;
	logic          irq_meta;
	logic          irq_sync;
	logic          irq_prev;
	logic          irq_pend;
	logic          irq_taken;

	function automatic logic uses_index(input logic [3:0] op);
		return (op == RM_COMPARE_IDX) || (op == RM_LOAD_IDX) || (op == RM_STORE_IDX);
	endfunction

	function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] off);
		return base + {{8{off[7]}}, off};
	endfunction

	function automatic logic [7:0] sp_step(input logic [7:0] s, input logic up);
		// The stack stays inside the top quarter of page zero, wrapping there.
		return {STACK_TOP, up ? s[5:0] + 6'h01 : s[5:0] - 6'h01};
	endfunction

	assign grp = opcode[7:4];
	assign low = opcode[3:0];
	assign rmw_grp = (grp >= GRP_RMW_DIR) && (grp <= GRP_RMW_IX0);
	assign product = {8'h00, acc} * {8'h00, idx};

	always_comb
	begin
		alu_lhs = uses_index(low) ? idx : acc;
		alu_rhs = mem_rdata;
		if (grp == GRP_RMW_ACC)
			alu_rhs = acc;
		else if (grp == GRP_RMW_IDX)
			alu_rhs = idx;
		unique case (stk_cnt)
			STK_PCL: push_data = pc[7:0];
			STK_PCH: push_data = pc[15:8];
			STK_IDX: push_data = idx;
			STK_ACC: push_data = acc;
			default: push_data = {CCR_PAD, ccr};
		endcase
	end

	cis_alu u_alu (
		.rmw    (rmw_grp),
		.op     (low),
		.lhs    (alu_lhs),
		.rhs    (alu_rhs),
		.ccr_in (ccr),
		.out    (alu_out)
	);

	cis_bitop u_bitop (
		.byte_in   (mem_rdata),
		.bit_sel   (opcode[3:1]),
		.bit_level (~opcode[0]),
		.cond      (low),
		.ccr       (ccr),
		.byte_out  (bit_byte),
		.bit_val   (bit_val),
		.rel_take  (rel_take)
	);

	// The request pin is asynchronous, so it is synchronised before edge detection.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			irq_meta <= 1'b1;
			irq_sync <= 1'b1;
			irq_prev <= 1'b1;
			irq_pend <= 1'b0;
		end
		else
		begin
			irq_meta <= irq_n;
			irq_sync <= irq_meta;
			irq_prev <= irq_sync;
			// A new falling edge wins over the acknowledge in the same cycle.
			irq_pend <= (irq_prev & ~irq_sync) | (irq_pend & ~irq_taken);
		end
	end

	always_ff @(posedge clock)
	begin
		mem_req.rd <= 1'b0;
		mem_req.wr <= 1'b0;
		irq_taken <= 1'b0;
		if (reset)
		begin
			acc <= DATA_RESET;
			idx <= DATA_RESET;
			sp <= SP_RESET;
			pc <= PC_RESET;
			ccr <= CCR_RESET;
			opcode <= DATA_RESET;
			ea <= PC_RESET;
			vec <= RESET_VEC;
			stk_cnt <= STK_PCL;
			stk_last <= STK_PCL;
			push_vec <= 1'b0;
			br_take <= 1'b0;
			osc_stopped <= 1'b0;
			cpu_idle <= 1'b0;
			mem_req.addr <= RESET_VEC;
			mem_req.wdata <= DATA_RESET;
			mem_req.rd <= 1'b1;
			ret_state <= ST_VEC_HI;
			state <= ST_WAIT;
		end
		else
		begin
			unique case (state)
				ST_FETCH:
					if (irq_pend && !ccr.i)
					begin
						irq_taken <= 1'b1;
						vec <= IRQ_VEC;
						push_vec <= 1'b1;
						stk_cnt <= STK_PCL;
						stk_last <= STK_CCR;
						state <= ST_PUSH;
					end
					else
					begin
						mem_req.addr <= pc;
						mem_req.rd <= 1'b1;
						pc <= pc + 16'h0001;
						ret_state <= ST_DECODE;
						state <= ST_WAIT;
					end
				ST_WAIT:
					state <= ret_state;
				ST_DECODE:
				begin
					opcode <= mem_rdata;
					state <= ST_ADDR;
				end
				ST_ADDR:
				begin
					state <= ST_FETCH;
					unique case (grp)
						GRP_RMW_ACC, GRP_RMW_IDX:
							if (opcode == UNSIGNED_PRODUCT_OP)
							begin
								{idx, acc} <= product;
								ccr.h <= 1'b0;
								ccr.c <= 1'b0;
							end
							else
							begin
								ccr <= alu_out.ccr;
								if (low != PROBE_FLAGS_OP && grp == GRP_RMW_ACC)
									acc <= alu_out.res;
								else if (low != PROBE_FLAGS_OP)
									idx <= alu_out.res;
							end
						GRP_RMW_IX0, GRP_IX0:
						begin
							ea <= {PAGE_ZERO, idx};
							state <= ST_ACCESS;
						end
						GRP_CTRL_A, GRP_CTRL_B:
							unique case (opcode)
								ACC_TO_INDEX_OP: idx <= acc;
								INDEX_TO_ACC_OP: acc <= idx;
								CARRY_ZERO_OP: ccr.c <= 1'b0;
								CARRY_ONE_OP: ccr.c <= 1'b1;
								IRQ_MASK_OFF_OP: ccr.i <= 1'b0;
								IRQ_MASK_ON_OP: ccr.i <= 1'b1;
								STACK_POINTER_INIT_OP: sp <= SP_RESET;
								OSC_HALT_OP:
								begin
									ccr.i <= 1'b0;
									osc_stopped <= 1'b1;
									state <= ST_SLEEP;
								end
								CLOCK_IDLE_OP:
								begin
									ccr.i <= 1'b0;
									cpu_idle <= 1'b1;
									state <= ST_SLEEP;
								end
								SUB_RETURN_OP:
								begin
									stk_cnt <= STK_PCH;
									state <= ST_PULL;
								end
								INTERRUPT_RETURN_OP:
								begin
									stk_cnt <= STK_CCR;
									state <= ST_PULL;
								end
								SOFT_TRAP_OP:
								begin
									vec <= SOFT_TRAP_VEC;
									push_vec <= 1'b1;
									stk_cnt <= STK_PCL;
									stk_last <= STK_CCR;
									state <= ST_PUSH;
								end
								default: ccr <= ccr;
							endcase
						default:
						begin
							mem_req.addr <= pc;
							mem_req.rd <= 1'b1;
							pc <= pc + 16'h0001;
							ret_state <= ST_OPND1;
							state <= ST_WAIT;
						end
					endcase
				end
				ST_OPND1:
					unique case (grp)
						GRP_IMM:
							state <= ST_EXEC;
						GRP_REL_BRANCH:
						begin
							if (rel_take)
								pc <= rel_target(pc, mem_rdata);
							state <= ST_FETCH;
						end
						GRP_EXT, GRP_IX2:
						begin
							ea[15:8] <= mem_rdata;
							mem_req.addr <= pc;
							mem_req.rd <= 1'b1;
							pc <= pc + 16'h0001;
							ret_state <= ST_OPND2;
							state <= ST_WAIT;
						end
						GRP_RMW_IX1, GRP_IX1:
						begin
							ea <= {PAGE_ZERO, mem_rdata} + {PAGE_ZERO, idx};
							state <= ST_ACCESS;
						end
						default:
						begin
							ea <= {PAGE_ZERO, mem_rdata};
							state <= ST_ACCESS;
						end
					endcase
				ST_OPND2:
				begin
					if (grp == GRP_IX2)
						ea <= {ea[15:8], mem_rdata} + {PAGE_ZERO, idx};
					else
						ea <= {ea[15:8], mem_rdata};
					state <= ST_ACCESS;
				end
				ST_ACCESS:
					if (!rmw_grp && low == UNCONDITIONAL_GOTO_OP && grp >= GRP_IMM)
					begin
						pc <= ea;
						state <= ST_FETCH;
					end
					else if (!rmw_grp && low == SUBROUTINE_CALL_OP && grp >= GRP_IMM)
					begin
						push_vec <= 1'b0;
						stk_cnt <= STK_PCL;
						stk_last <= STK_PCH;
						state <= ST_PUSH;
					end
					else if (grp >= GRP_IMM && (low == RM_STORE_ACC || low == RM_STORE_IDX))
					begin
						mem_req.addr <= ea;
						mem_req.wdata <= alu_out.res;
						mem_req.wr <= 1'b1;
						ccr <= alu_out.ccr;
						state <= ST_FETCH;
					end
					else
					begin
						mem_req.addr <= ea;
						mem_req.rd <= 1'b1;
						ret_state <= ST_EXEC;
						state <= ST_WAIT;
					end
				ST_EXEC:
				begin
					state <= ST_FETCH;
					unique case (grp)
						GRP_BIT_BRANCH:
						begin
							ccr.c <= bit_val;
							br_take <= (bit_val == ~opcode[0]);
							mem_req.addr <= pc;
							mem_req.rd <= 1'b1;
							pc <= pc + 16'h0001;
							ret_state <= ST_BROFF;
							state <= ST_WAIT;
						end
						GRP_BIT_WRITE:
						begin
							mem_req.addr <= ea;
							mem_req.wdata <= bit_byte;
							mem_req.wr <= 1'b1;
						end
						GRP_RMW_DIR, GRP_RMW_IX1, GRP_RMW_IX0:
						begin
							ccr <= alu_out.ccr;
							mem_req.addr <= ea;
							mem_req.wdata <= alu_out.res;
							mem_req.wr <= (low != PROBE_FLAGS_OP);
						end
						default:
						begin
							ccr <= alu_out.ccr;
							unique case (low)
								RM_SUBTRACT, RM_SUBTRACT_CARRY, RM_AND, RM_LOAD_ACC,
								RM_XOR, RM_ADD_CARRY, RM_OR, RM_ADD:
									acc <= alu_out.res;
								RM_LOAD_IDX:
									idx <= alu_out.res;
								default:
									acc <= acc;
							endcase
						end
					endcase
				end
				ST_BROFF:
				begin
					if (br_take)
						pc <= rel_target(pc, mem_rdata);
					state <= ST_FETCH;
				end
				ST_PUSH:
				begin
					mem_req.addr <= {PAGE_ZERO, sp};
					mem_req.wdata <= push_data;
					mem_req.wr <= 1'b1;
					sp <= sp_step(sp, 1'b0);
					stk_cnt <= stk_cnt + 3'h1;
					if (stk_cnt == stk_last && push_vec)
					begin
						ccr.i <= 1'b1;
						state <= ST_VEC_HI;
					end
					else if (stk_cnt == stk_last)
					begin
						pc <= ea;
						state <= ST_FETCH;
					end
				end
				ST_PULL:
				begin
					sp <= sp_step(sp, 1'b1);
					mem_req.addr <= {PAGE_ZERO, sp_step(sp, 1'b1)};
					mem_req.rd <= 1'b1;
					ret_state <= ST_PULLD;
					state <= ST_WAIT;
				end
				ST_PULLD:
				begin
					unique case (stk_cnt)
						STK_PCL: pc[7:0] <= mem_rdata;
						STK_PCH: pc[15:8] <= mem_rdata;
						STK_IDX: idx <= mem_rdata;
						STK_ACC: acc <= mem_rdata;
						default: ccr <= cis_ccr_t'(mem_rdata[4:0]);
					endcase
					stk_cnt <= stk_cnt - 3'h1;
					state <= (stk_cnt == STK_PCL) ? ST_FETCH : ST_PULL;
				end
				ST_VEC_HI:
					// The last stack write must finish before the vector read starts.
					if (!mem_req.wr)
					begin
						pc[15:8] <= mem_rdata;
						mem_req.addr <= vec + 16'h0001;
						mem_req.rd <= 1'b1;
						ret_state <= ST_VEC_LO;
						state <= ST_WAIT;
					end
					else
					begin
						mem_req.addr <= vec;
						mem_req.rd <= 1'b1;
						ret_state <= ST_VEC_HI;
						state <= ST_WAIT;
					end
				ST_VEC_LO:
				begin
					pc[7:0] <= mem_rdata;
					state <= ST_FETCH;
				end
				ST_SLEEP:
					if (irq_pend)
					begin
						osc_stopped <= 1'b0;
						cpu_idle <= 1'b0;
						state <= ST_FETCH;
					end
				default:
					state <= ST_FETCH;
			endcase
		end
	end
endmodule

// *** cis_core_properties.sv ***
// Concurrent checks on the ports of the CPU core.
`timescale 1ns/1ps
module cis_core_checker (
	input wire logic             clock,
	input wire logic             reset,
	input wire logic             irq_n,
	input wire logic [7:0]       mem_rdata,
	input cis_pkg::cis_mem_req_t mem_req,
	input wire logic             osc_stopped,
	input wire logic             cpu_idle
);
	import cis_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	logic busy;
	logic asleep;
	assign busy = mem_req.rd || mem_req.wr;
	assign asleep = osc_stopped || cpu_idle;
	a_access_spacing: assert property (mem_req.rd |=> !mem_req.rd)
		else $error("read strobes in adjacent cycles");
	a_strobe_exclusive: assert property (!(mem_req.rd && mem_req.wr))
		else $error("read and write strobes together");
	a_vector_pair: assert property ($past(reset) |-> ##[1:4] (mem_req.rd && mem_req.addr == 16'hFFFF))
		else $error("second vector byte not read after reset");
	a_sleep_exclusive: assert property (!(osc_stopped && cpu_idle))
		else $error("both sleep outputs high");
	a_sleep_quiet: assert property ($past(asleep) && asleep |-> !busy)
		else $error("bus access while asleep");
	a_halt_wakes: assert property (osc_stopped && $fell(irq_n) |-> ##[1:8] !osc_stopped)
		else $error("halt not left after interrupt pin fell");
	a_idle_wakes: assert property (cpu_idle && $fell(irq_n) |-> ##[1:8] !cpu_idle)
		else $error("idle not left after interrupt");
	a_wake_vector: assert property ($fell(asleep) |-> ##[1:40] (mem_req.rd && mem_req.addr == IRQ_VEC))
		else $error("no interrupt vector read after wake");
	cover property (osc_stopped);
	cover property (cpu_idle);
	cover property (mem_req.wr && mem_req.addr == 16'h00FF);
endmodule

// *** cis_mem_model.sv ***
// Behavioural on-chip memory answering the core's read and write strobes.
`timescale 1ns/1ps
module cis_mem_model (
	input wire logic             clock,
	input cis_pkg::cis_mem_req_t mem_req,
	output logic [7:0]           mem_rdata
);
	import cis_pkg::*;
	// every cell reads back
	// Every cell reads back what was last written, so modify ops are safe anywhere.
	logic [7:0] mem [0:65535];
	initial
	begin
		mem_rdata = 8'h00;
		for (int i = 0; i < 65536; i++)
			mem[i] = IDLE_OP;
	end
	// Data lands one cycle after the strobe and stands until the next read.
	always @(posedge clock)
	begin
		if (mem_req.rd)
			mem_rdata <= mem[mem_req.addr];
		if (mem_req.wr)
			mem[mem_req.addr] <= mem_req.wdata;
	end
endmodule

// *** cpu_instruction_semantics_tb_top.sv ***
// Self-checking bench: short programs run from the memory model and results are compared.
`timescale 1ns/1ps
`define CHK(got, want) \
	begin \
		check_count++; \
		if ((got) !== (want)) \
		begin \
			error_cnt++; \
			$display("ERROR %0t: got %h expected %h", $time, (got), (want)); \
		end \
	end
module cpu_instruction_semantics_tb_top;
	import cis_pkg::*;
	logic         clock;
	logic         reset = 1'b1;
	logic         irq_n = 1'b1;
	logic [7:0]   mem_rdata;
	cis_mem_req_t mem_req;
	logic         osc_stopped;
	logic         cpu_idle;
	logic         done = 1'b0;
	logic [15:0]  watch = 16'h0000;
	int           hits = 0;
	int           error_cnt = 0;
	int           check_count = 0;
	int           cycles = 0;

	cis_core dut_u (.clock(clock), .reset(reset), .irq_n(irq_n), .mem_rdata(mem_rdata),
		.mem_req(mem_req), .osc_stopped(osc_stopped), .cpu_idle(cpu_idle));
	cis_mem_model mem_u (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

	initial
	begin
		clock = 1'b0;
		forever
			#5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		done |= mem_req.wr && mem_req.addr == 16'h00F0;
		hits += int'(mem_req.wr && mem_req.addr == watch);
		if (cycles == 60000)
		begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("Checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Reset is raised first so that no program changes under a running loop.
	task automatic load(input logic [15:0] a, input logic [7:0] q[$]);
		reset = 1'b1;
		foreach (q[i])
			mem_u.mem[16'(a + i)] = q[i];
	endtask

	task automatic boot(input logic [15:0] start);
		load(16'hFFFE, '{start[15:8], start[7:0]});
		repeat (3) @(negedge clock);
		reset = 1'b0;
		done = 1'b0;
		hits = 0;
	endtask

	task automatic await_done();
		for (int i = 0; i < 400 && !done; i++)
			@(negedge clock);
		`CHK(done, 1'b1)
	endtask

	task automatic t_modify();
		// Op, carry in, value, carry out; FF means the carry is not judged.
		logic [31:0] tbl [13] = '{32'h3000_7F01, 32'h3300_7E01, 32'h3401_4001, 32'h3601_C001,
			32'h3600_4001, 32'h3700_C001, 32'h3800_0201, 32'h3901_0301, 32'h3900_0201,
			32'h3A00_80FF, 32'h3C00_82FF, 32'h3D00_81FF, 32'h3F00_00FF};
		foreach (tbl[k])
		begin
			load(16'h0100, '{tbl[k][16] ? CARRY_ONE_OP : CARRY_ZERO_OP, tbl[k][31:24], 8'h80,
				8'hA6, 8'h00, 8'h49, 8'hB7, 8'hF0, 8'h20, 8'hFE});
			mem_u.mem[16'h0080] = 8'h81;
			watch = 16'h0080;
			boot(16'h0100);
			await_done();
			`CHK(mem_u.mem[16'h0080], tbl[k][15:8])
			`CHK(hits, (tbl[k][31:24] == 8'h3D) ? 0 : 1)
			if (tbl[k][7:0] != 8'hFF)
				`CHK(mem_u.mem[16'h00F0], tbl[k][7:0])
		end
	endtask

	task automatic t_bit_write();
		for (int b = 0; b < 8; b++)
			for (int c = 0; c < 2; c++)
			begin
				load(16'h0100, '{8'(16 + 2 * b + c), 8'hFF, 8'hB7, 8'hF0, 8'h20, 8'hFE});
				mem_u.mem[16'h00FF] = 8'h5A;
				watch = 16'h00FF;
				boot(16'h0100);
				await_done();
				`CHK(mem_u.mem[16'h00FF], c ? 8'h5A & ~(8'h01 << b) : 8'h5A | (8'h01 << b))
				`CHK(hits, 1)
			end
	endtask

	task automatic t_bit_branch();
		logic [15:0] base;
		logic [7:0]  pat = 8'hA5;
		logic        taken;
		for (int b = 0; b < 8; b++)
			for (int p = 0; p < 2; p++)
			begin
				base = (b == 7) ? 16'h018D : (b == 6) ? 16'h008E : 16'h0100;
				taken = pat[b] ^ p[0];
				load(base, '{8'(2 * b + p), 8'hFE, 8'(16'h0110 - base - 16'h0003),
					8'hAE, 8'h11, 8'hCC, 8'h01, 8'h10});
				load(16'h0110, '{8'hA6, 8'h00, 8'h49, 8'hBF, 8'hF1, 8'hB7, 8'hF0, 8'h20, 8'hFE});
				mem_u.mem[16'h00FE] = pat;
				boot(base);
				await_done();
				`CHK(mem_u.mem[16'h00F1], taken ? 8'h00 : 8'h11)
				`CHK(mem_u.mem[16'h00F0], {7'h00, pat[b]})
			end
	endtask

	task automatic t_transfer();
		logic [15:0] prod;
		prod = 16'h00F3 * 16'h002D;
		load(16'h0100, '{8'hA6, 8'hF3, 8'hAE, 8'h2D, 8'h42, 8'hBF, 8'hF1, 8'hB7, 8'hF2, 8'hA6,
			8'h5C, 8'h97, 8'hA6, 8'h00, 8'hBF, 8'hF3, 8'h9F, 8'hBD, 8'h30,
			8'hB7, 8'hF0, 8'h20, 8'hFE});
		load(16'h0030, '{8'hB7, 8'hF4, 8'h81});
		boot(16'h0100);
		await_done();
		`CHK(mem_u.mem[16'h00F4], 8'h5C)
		`CHK({mem_u.mem[16'h00FE], mem_u.mem[16'h00FF]}, 16'h0113)
		`CHK(mem_u.mem[16'h00F1], prod[15:8])
		`CHK(mem_u.mem[16'h00F2], prod[7:0])
		`CHK(mem_u.mem[16'h00F3], 8'h5C)
		`CHK(mem_u.mem[16'h00F0], 8'h5C)
	endtask

	task automatic t_sleep();
		for (int s = 0; s < 2; s++)
		begin
			load(16'hFFFA, '{8'h01, 8'h40});
			load(16'h0140, '{8'hA6, 8'h77, 8'hB7, 8'hF5, 8'h80});
			load(16'h0120, '{s ? CLOCK_IDLE_OP : OSC_HALT_OP, 8'hB7, 8'hF0, 8'h20, 8'hFE});
			mem_u.mem[16'h00F0] = 8'hEE;
			mem_u.mem[16'h00F5] = 8'h00;
			boot(16'h0120);
			for (int i = 0; i < 100 && !(osc_stopped || cpu_idle); i++)
				@(negedge clock);
			`CHK(osc_stopped, s ? 1'b0 : 1'b1)
			`CHK(cpu_idle, s ? 1'b1 : 1'b0)
			// one request only
			// A single request per run, so repeats are always far apart.
			irq_n = 1'b0;
			await_done();
			irq_n = 1'b1;
			`CHK(mem_u.mem[16'h00F5], 8'h77)
			// The service routine returns, so the accumulator comes back from the stack.
			`CHK(mem_u.mem[16'h00F0], 8'h00)
			`CHK(osc_stopped || cpu_idle, 1'b0)
		end
	endtask

	initial
	begin
		// The memory model fills itself at time zero, so programs are loaded after it.
		#1;
		t_modify();
		t_bit_write();
		t_bit_branch();
		t_transfer();
		t_sleep();
		wrap_up();
	end
endmodule

bind cis_core cis_core_checker chk_u (.clock(clock), .reset(reset), .irq_n(irq_n),
	.mem_rdata(mem_rdata), .mem_req(mem_req), .osc_stopped(osc_stopped), .cpu_idle(cpu_idle));
